// [profile_mode_selector.sv]
module profile_mode_selector (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  fb_state_req,
  input  wire logic        map_has_ctrl,
  input  wire logic        sdo_req,
  input  wire logic [2:0]  sdo_cmd,
  input  wire logic [15:0] sdo_index,
  input  wire logic [15:0] sdo_size,
  input  wire logic [3:0]  sdo_len,
  input  wire logic        sdo_toggle,
  input  wire logic [31:0] sdo_wdata,
  input  wire logic [15:0] pdo_ctrl_word,
  input  wire logic [15:0] vendor_ctrl_word,
  input  wire logic [15:0] drive_status_word,
  input  wire logic [15:0] profile_ctrl_out,
  input  wire logic [15:0] profile_status_in,
  input  wire logic        app_fault,
  input  wire logic        comm_fault,
  output logic      [3:0]  fb_state,
  output logic      [7:0]  mode_display,
  output logic             profile_active,
  output logic             sdo_ack,
  output logic      [1:0]  sdo_rsp,
  output logic      [31:0] sdo_rdata,
  output logic      [3:0]  sdo_rlen,
  output logic      [31:0] sdo_abort_code,
  output logic      [15:0] drive_ctrl_word,
  output logic      [15:0] status_word_out,
  output logic      [15:0] profile_ctrl_in,
  output logic             emcy_valid,
  output logic      [15:0] emcy_code
);

  function automatic logic early_state(input logic [3:0] st);
    early_state = (st != mode_sel_pkg::FB_SAFEOP) && (st != mode_sel_pkg::FB_OP);
  endfunction : early_state

  logic [3:0]  fb_q;
  logic        prof_q;
  logic        prof_d;
  logic [3:0]  st_d;
  logic        legal;
  mode_sel_pkg::xfer_type xfer_q;
  logic [15:0] remain_q;
  logic        tog_q;
  logic [15:0] wbuf_q;
  logic        app_fault_q;
  logic        comm_fault_q;
  logic        is_ctrl;
  logic        is_stat;
  logic        refuse;

  assign is_ctrl = sdo_index == mode_sel_pkg::OBJ_CTRL_WORD;
  assign is_stat = sdo_index == mode_sel_pkg::OBJ_STAT_WORD;
  assign refuse  = !prof_q && !prof_d && is_ctrl;

  // Fieldbus state accepts only one-hot legal codes
  always_comb begin
    legal = (fb_state_req == mode_sel_pkg::FB_INIT)   || (fb_state_req == mode_sel_pkg::FB_PREOP) ||
            (fb_state_req == mode_sel_pkg::FB_SAFEOP) || (fb_state_req == mode_sel_pkg::FB_OP);
    st_d = legal ? fb_state_req : fb_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fb_q <= mode_sel_pkg::FB_INIT;
    end else begin
      fb_q <= st_d;
    end
  end

  // Mode selection
  always_comb begin
    prof_d = prof_q;
    if (map_has_ctrl && !early_state(st_d)) begin
      prof_d = 1'b1;
    end else if (early_state(st_d) && sdo_req && is_ctrl &&
                 (sdo_cmd == mode_sel_pkg::CMD_DL_EXP || sdo_cmd == mode_sel_pkg::CMD_DL_NORM)) begin
      prof_d = 1'b1;
    end else if (early_state(st_d) && sdo_req && is_stat &&
                 (sdo_cmd == mode_sel_pkg::CMD_UL_EXP || sdo_cmd == mode_sel_pkg::CMD_UL_NORM)) begin
      prof_d = 1'b1;
    end else if (!early_state(st_d) && !map_has_ctrl) begin
      prof_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prof_q       <= 1'b0;
      mode_display <= mode_sel_pkg::MODE_VENDOR;
    end else begin
      prof_q       <= prof_d;
      mode_display <= prof_d ? mode_sel_pkg::MODE_VELOCITY : mode_sel_pkg::MODE_VENDOR;
    end
  end

  // Control and status word routing
  always_ff @(posedge clk) begin
    if (rst) begin
      drive_ctrl_word <= 16'h0000;
      status_word_out <= 16'h0000;
      profile_ctrl_in <= 16'h0000;
    end else begin
      profile_ctrl_in <= (fb_q == mode_sel_pkg::FB_OP) ? pdo_ctrl_word : wbuf_q;
      if (prof_q) begin
        drive_ctrl_word <= profile_ctrl_out;
        status_word_out <= profile_status_in;
      end else begin
        drive_ctrl_word <= (fb_q == mode_sel_pkg::FB_OP) ? vendor_ctrl_word : 16'h0000;
        status_word_out <= drive_status_word;
      end
    end
  end

  // Service-data server
  always_ff @(posedge clk) begin
    if (rst) begin
      xfer_q         <= mode_sel_pkg::ST_IDLE;
      remain_q       <= 16'h0000;
      tog_q          <= 1'b0;
      wbuf_q         <= 16'h0000;
      sdo_ack        <= 1'b0;
      sdo_rsp        <= mode_sel_pkg::RSP_OK;
      sdo_rdata      <= 32'h0000_0000;
      sdo_rlen       <= 4'h0;
      sdo_abort_code <= 32'h0000_0000;
    end else begin
      sdo_ack <= sdo_req;
      if (sdo_req) begin
        sdo_rsp        <= mode_sel_pkg::RSP_OK;
        sdo_rdata      <= 32'h0000_0000;
        sdo_rlen       <= 4'h0;
        sdo_abort_code <= 32'h0000_0000;
        case (sdo_cmd)
          mode_sel_pkg::CMD_DL_EXP, mode_sel_pkg::CMD_UL_EXP,
          mode_sel_pkg::CMD_DL_NORM, mode_sel_pkg::CMD_UL_NORM: begin
            if (refuse) begin
              sdo_rsp        <= mode_sel_pkg::RSP_ABORT;
              sdo_abort_code <= mode_sel_pkg::ABT_ACCESS;
              xfer_q         <= mode_sel_pkg::ST_IDLE;
            end else if (sdo_cmd == mode_sel_pkg::CMD_DL_EXP) begin
              if (sdo_len > mode_sel_pkg::EXP_MAX_OCTETS || sdo_len == 4'h0) begin
                sdo_rsp        <= mode_sel_pkg::RSP_ABORT;
                sdo_abort_code <= mode_sel_pkg::ABT_SIZE;
              end else if (is_ctrl) begin
                wbuf_q <= sdo_wdata[15:0];
              end
              xfer_q <= mode_sel_pkg::ST_IDLE;
            end else if (sdo_cmd == mode_sel_pkg::CMD_UL_EXP) begin
              sdo_rlen  <= mode_sel_pkg::EXP_MAX_OCTETS;
              sdo_rdata <= is_stat ? {16'h0000, status_word_out} :
                           (sdo_index == mode_sel_pkg::OBJ_MODE_DISP) ?
                           {24'h00_0000, mode_display} : 32'h0000_0000;
              xfer_q    <= mode_sel_pkg::ST_IDLE;
            end else if (sdo_size > mode_sel_pkg::NEG_OCTETS) begin
              sdo_rsp  <= mode_sel_pkg::RSP_SEG_MORE;
              remain_q <= sdo_size - mode_sel_pkg::NEG_OCTETS;
              tog_q    <= 1'b0;
              xfer_q   <= (sdo_cmd == mode_sel_pkg::CMD_DL_NORM) ?
                          mode_sel_pkg::ST_DL : mode_sel_pkg::ST_UL;
            end else begin
              xfer_q <= mode_sel_pkg::ST_IDLE;
            end
          end
          mode_sel_pkg::CMD_DL_SEG, mode_sel_pkg::CMD_UL_SEG: begin
            if ((sdo_cmd == mode_sel_pkg::CMD_DL_SEG && xfer_q != mode_sel_pkg::ST_DL) ||
                (sdo_cmd == mode_sel_pkg::CMD_UL_SEG && xfer_q != mode_sel_pkg::ST_UL) ||
                sdo_toggle != tog_q) begin
              sdo_rsp        <= mode_sel_pkg::RSP_ABORT;
              sdo_abort_code <= mode_sel_pkg::ABT_SEQ;
              xfer_q         <= mode_sel_pkg::ST_IDLE;
            end else begin
              tog_q <= ~tog_q;
              if (sdo_cmd == mode_sel_pkg::CMD_UL_SEG) begin
                sdo_rlen <= (remain_q > {12'h000, mode_sel_pkg::SEG_OCTETS}) ?
                            mode_sel_pkg::SEG_OCTETS : remain_q[3:0];
              end
              if (remain_q > {12'h000, mode_sel_pkg::SEG_OCTETS}) begin
                remain_q <= remain_q - {12'h000, mode_sel_pkg::SEG_OCTETS};
                sdo_rsp  <= mode_sel_pkg::RSP_SEG_MORE;
              end else begin
                remain_q <= 16'h0000;
                xfer_q   <= mode_sel_pkg::ST_IDLE;
              end
            end
          end
          mode_sel_pkg::CMD_ABORT: begin
            xfer_q <= mode_sel_pkg::ST_IDLE;
          end
          default: begin
            sdo_rsp        <= mode_sel_pkg::RSP_ABORT;
            sdo_abort_code <= mode_sel_pkg::ABT_ACCESS;
            xfer_q         <= mode_sel_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // Emergency reports on fault rising edges; no request input exists
  always_ff @(posedge clk) begin
    if (rst) begin
      app_fault_q  <= 1'b0;
      comm_fault_q <= 1'b0;
      emcy_valid   <= 1'b0;
      emcy_code    <= 16'h0000;
    end else begin
      app_fault_q  <= app_fault;
      comm_fault_q <= comm_fault;
      emcy_valid   <= (app_fault && !app_fault_q) || (comm_fault && !comm_fault_q);
      if (app_fault && !app_fault_q) begin
        emcy_code <= mode_sel_pkg::EMCY_APP;
      end else if (comm_fault && !comm_fault_q) begin
        emcy_code <= mode_sel_pkg::EMCY_COMM;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fb_state       <= mode_sel_pkg::FB_INIT;
      profile_active <= 1'b0;
    end else begin
      fb_state       <= st_d;
      profile_active <= prof_d;
    end
  end

endmodule : profile_mode_selector

// [mode_sel_pkg.sv]
package mode_sel_pkg;

  // Fieldbus states
  localparam logic [3:0] FB_INIT     = 4'h1;
  localparam logic [3:0] FB_PREOP    = 4'h2;
  localparam logic [3:0] FB_SAFEOP   = 4'h4;
  localparam logic [3:0] FB_OP       = 4'h8;

  // Object indices
  localparam logic [15:0] OBJ_CTRL_WORD   = 16'h6040;
  localparam logic [15:0] OBJ_STAT_WORD   = 16'h6041;
  localparam logic [15:0] OBJ_MODE_DISP   = 16'h6061;

  // Mode display values
  localparam logic [7:0] MODE_VELOCITY   = 8'h02;
  localparam logic [7:0] MODE_VENDOR     = 8'hFE;

  // Service-data commands
  localparam logic [2:0] CMD_DL_EXP      = 3'h0;
  localparam logic [2:0] CMD_DL_NORM     = 3'h1;
  localparam logic [2:0] CMD_DL_SEG      = 3'h2;
  localparam logic [2:0] CMD_UL_EXP      = 3'h3;
  localparam logic [2:0] CMD_UL_NORM     = 3'h4;
  localparam logic [2:0] CMD_UL_SEG      = 3'h5;
  localparam logic [2:0] CMD_ABORT       = 3'h6;

  // Response codes
  localparam logic [1:0] RSP_OK          = 2'h0;
  localparam logic [1:0] RSP_SEG_MORE    = 2'h1;
  localparam logic [1:0] RSP_ABORT       = 2'h2;

  localparam logic [3:0] EXP_MAX_OCTETS  = 4'h4;
  localparam logic [15:0] NEG_OCTETS     = 16'h0008;
  localparam logic [3:0] SEG_OCTETS      = 4'h4;

  // Abort codes (plain values)
  localparam logic [31:0] ABT_SIZE       = 32'h0607_0010;
  localparam logic [31:0] ABT_ACCESS     = 32'h0601_0000;
  localparam logic [31:0] ABT_SEQ        = 32'h0504_0001;

  localparam logic [15:0] EMCY_APP       = 16'h1000;
  localparam logic [15:0] EMCY_COMM      = 16'h8100;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DL   = 3'b010,
    ST_UL   = 3'b100
  } xfer_type;

endpackage : mode_sel_pkg

// [mode_sel_props.sv]
module mode_sel_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        sdo_req,
  input wire logic [2:0]  sdo_cmd,
  input wire logic [15:0] sdo_index,
  input wire logic [3:0]  sdo_len,
  input wire logic [3:0]  fb_state,
  input wire logic        map_has_ctrl,
  input wire logic [7:0]  mode_display,
  input wire logic        profile_active,
  input wire logic        sdo_ack,
  input wire logic [1:0]  sdo_rsp,
  input wire logic [3:0]  sdo_rlen,
  input wire logic [31:0] sdo_abort_code,
  input wire logic [15:0] drive_status_word,
  input wire logic [15:0] status_word_out,
  input wire logic        app_fault,
  input wire logic        emcy_valid,
  input wire logic [15:0] emcy_code
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  logic no_ctl;
  assign no_ctl = sdo_index != mode_sel_pkg::OBJ_CTRL_WORD;
  a_show_velocity: assert property (
    profile_active |-> mode_display == mode_sel_pkg::MODE_VELOCITY) else $error("bad mode");
  a_show_vendor: assert property (
    !profile_active |-> mode_display == mode_sel_pkg::MODE_VENDOR) else $error("bad mode");
  a_ack_next: assert property (
    sdo_req |=> sdo_ack) else $error("no ack");
  a_ctrl_refused: assert property (
    sdo_req && !no_ctl && !profile_active && !map_has_ctrl && fb_state[3:2] != 2'b00 &&
    (sdo_cmd == mode_sel_pkg::CMD_DL_EXP || sdo_cmd == mode_sel_pkg::CMD_DL_NORM ||
     sdo_cmd == mode_sel_pkg::CMD_UL_EXP || sdo_cmd == mode_sel_pkg::CMD_UL_NORM)
    |=> sdo_rsp == mode_sel_pkg::RSP_ABORT && sdo_abort_code == mode_sel_pkg::ABT_ACCESS)
    else $error("ctrl not refused");
  a_exp_size: assert property (
    sdo_req && sdo_cmd == mode_sel_pkg::CMD_DL_EXP && no_ctl && (sdo_len == 4'h0 || sdo_len > 4'h4)
    |=> sdo_abort_code == mode_sel_pkg::ABT_SIZE) else $error("size not aborted");
  a_upload_four: assert property (
    sdo_req && sdo_cmd == mode_sel_pkg::CMD_UL_EXP && no_ctl |=> sdo_rlen == 4'h4)
    else $error("bad rlen");
  a_vendor_pass: assert property (
    !profile_active && $past(!profile_active) && !$past(rst)
    |-> status_word_out == $past(drive_status_word)) else $error("status altered");
  a_emcy_app: assert property (
    $rose(app_fault) |-> ##[1:2] (emcy_valid && emcy_code == mode_sel_pkg::EMCY_APP))
    else $error("no emergency");
endmodule : mode_sel_props

bind profile_mode_selector mode_sel_props props_u (.*);

// [fb_master.sv]
module fb_master (
  input  wire logic        clk,
  input  wire logic        sdo_ack,
  output logic             sdo_req,
  output logic      [2:0]  sdo_cmd,
  output logic      [15:0] sdo_index,
  output logic      [15:0] sdo_size,
  output logic      [3:0]  sdo_len,
  output logic             sdo_toggle,
  output logic      [31:0] sdo_wdata,
  output logic      [3:0]  fb_state_req,
  output logic             map_has_ctrl,
  output logic      [15:0] pdo_ctrl_word
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {sdo_req, sdo_cmd, sdo_index, sdo_len, sdo_toggle, map_has_ctrl} = '0;
    sdo_size = 16'h000C;
    sdo_wdata = 32'h1234_5678;
    pdo_ctrl_word = 16'h0000;
    fb_state_req = mode_sel_pkg::FB_INIT;
  end
  task automatic go(input logic [3:0] s, input logic m);
    @(posedge clk);
    #1;
    fb_state_req = s;
    map_has_ctrl = m;
    pdo_ctrl_word = (s == mode_sel_pkg::FB_OP) ? 16'h000F : 16'h0000;
    repeat (3) @(posedge clk);
    #1;
  endtask : go
  // Length and segment toggle come from the caller
  task automatic sdo(input logic [2:0] c, input logic [15:0] i, input logic [3:0] n,
                     input logic t);
    @(posedge clk);
    #1;
    {sdo_req, sdo_cmd, sdo_index, sdo_len, sdo_toggle} = {1'b1, c, i, n, t};
    @(posedge clk);
    #1;
    sdo_req = 1'b0;
  endtask : sdo
endmodule : fb_master

// [test_profile_mode_selector.sv]
module test_profile_mode_selector;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        map_has_ctrl, sdo_req, sdo_toggle, app_fault, comm_fault;
  logic        profile_active, sdo_ack, emcy_valid;
  logic [1:0]  sdo_rsp;
  logic [2:0]  sdo_cmd;
  logic [3:0]  fb_state_req, sdo_len, fb_state, sdo_rlen;
  logic [7:0]  mode_display;
  logic [15:0] sdo_index, sdo_size, pdo_ctrl_word, vendor_ctrl_word, drive_status_word;
  logic [15:0] profile_ctrl_out, profile_status_in, drive_ctrl_word, status_word_out;
  logic [15:0] profile_ctrl_in, emcy_code;
  logic [31:0] sdo_wdata, sdo_rdata, sdo_abort_code;
  int          failures = 0;
  int          comparisons = 0;
  int          cyc = 0;
  profile_mode_selector dut_u (.*);
  fb_master master_u (.*);
  always #20 clk = ~clk;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic test_done;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      test_done();
    end
  end
  task automatic t_early;
    chk("state", fb_state, mode_sel_pkg::FB_INIT);
    master_u.go(mode_sel_pkg::FB_PREOP, 1'b0);
    master_u.sdo(mode_sel_pkg::CMD_UL_EXP, mode_sel_pkg::OBJ_STAT_WORD, 4'h0, 1'b0);
    chk("ack", sdo_ack, 1);
    chk("rlen", sdo_rlen, 4);
    master_u.go(mode_sel_pkg::FB_PREOP, 1'b0);
    chk("prof", profile_active, 1);
    master_u.go(mode_sel_pkg::FB_SAFEOP, 1'b0);
    chk("prof", profile_active, 0);
    master_u.go(mode_sel_pkg::FB_PREOP, 1'b0);
    master_u.sdo(mode_sel_pkg::CMD_DL_EXP, mode_sel_pkg::OBJ_CTRL_WORD, 4'h2, 1'b0);
    chk("rsp", sdo_rsp, mode_sel_pkg::RSP_OK);
    master_u.go(mode_sel_pkg::FB_PREOP, 1'b0);
    chk("prof", profile_active, 1);
    chk("mode", mode_display, mode_sel_pkg::MODE_VELOCITY);
  endtask : t_early
  task automatic t_vendor;
    master_u.go(mode_sel_pkg::FB_SAFEOP, 1'b0);
    master_u.go(mode_sel_pkg::FB_OP, 1'b0);
    chk("ctrl", drive_ctrl_word, vendor_ctrl_word);
    chk("mode", mode_display, mode_sel_pkg::MODE_VENDOR);
    chk("stat", status_word_out, drive_status_word);
    master_u.sdo(mode_sel_pkg::CMD_DL_EXP, mode_sel_pkg::OBJ_CTRL_WORD, 4'h2, 1'b0);
    chk("abort", sdo_abort_code, mode_sel_pkg::ABT_ACCESS);
    master_u.go(mode_sel_pkg::FB_SAFEOP, 1'b0);
    chk("ctrl", drive_ctrl_word, 0);
    master_u.go(mode_sel_pkg::FB_OP, 1'b1);
    chk("mode", mode_display, mode_sel_pkg::MODE_VELOCITY);
    chk("pctl", drive_ctrl_word, profile_ctrl_out);
    chk("pin", profile_ctrl_in, 16'h000F);
  endtask : t_vendor
  task automatic t_sdo;
    for (int n = 0; n < 6; n++) begin
      master_u.sdo(mode_sel_pkg::CMD_DL_EXP, 16'h2000, n[3:0], 1'b0);
      chk("rsp", sdo_rsp, (n > 0 && n < 5) ? 2'h0 : 2'h2);
    end
    for (int t = 0; t < 2; t++) begin
      master_u.sdo(mode_sel_pkg::CMD_DL_NORM, 16'h2000, 4'h0, 1'b0);
      chk("rsp", sdo_rsp, mode_sel_pkg::RSP_SEG_MORE);
      master_u.sdo(mode_sel_pkg::CMD_DL_SEG, 16'h2000, 4'h0, t[0]);
      chk("rsp", sdo_rsp, t ? 2'h2 : 2'h0);
    end
    chk("abort", sdo_abort_code, mode_sel_pkg::ABT_SEQ);
    master_u.sdo(mode_sel_pkg::CMD_UL_EXP, mode_sel_pkg::OBJ_STAT_WORD, 4'h0, 1'b0);
    chk("rdata", sdo_rdata, 32'h0000_0627);
    master_u.sdo(mode_sel_pkg::CMD_UL_NORM, 16'h2000, 4'h0, 1'b0);
    chk("rsp", sdo_rsp, mode_sel_pkg::RSP_SEG_MORE);
    master_u.sdo(mode_sel_pkg::CMD_UL_SEG, 16'h2000, 4'h0, 1'b0);
    chk("rsp", sdo_rsp, mode_sel_pkg::RSP_OK);
    chk("rlen", sdo_rlen, 4);
    master_u.sdo(mode_sel_pkg::CMD_UL_NORM, 16'h2000, 4'h0, 1'b0);
    master_u.sdo(mode_sel_pkg::CMD_ABORT, 16'h2000, 4'h0, 1'b0);
    chk("rsp", sdo_rsp, mode_sel_pkg::RSP_OK);
    master_u.sdo(mode_sel_pkg::CMD_UL_SEG, 16'h2000, 4'h0, 1'b0);
    chk("abort", sdo_abort_code, mode_sel_pkg::ABT_SEQ);
  endtask : t_sdo
  task automatic t_emcy(input logic a, input logic [15:0] e);
    @(posedge clk);
    #1;
    {app_fault, comm_fault} = {a, !a};
    repeat (3) begin
      @(posedge clk);
      #1;
      if (emcy_valid === 1'b1) break;
    end
    chk("emcyv", emcy_valid, 1);
    chk("emcy", emcy_code, e);
    {app_fault, comm_fault} = 2'b00;
  endtask : t_emcy
  initial begin
    {app_fault, comm_fault} = 2'b00;
    vendor_ctrl_word = 16'hA5C3;
    drive_status_word = 16'h0237;
    profile_ctrl_out = 16'h000F;
    profile_status_in = 16'h0627;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    t_early();
    t_vendor();
    t_sdo();
    t_emcy(1'b1, mode_sel_pkg::EMCY_APP);
    t_emcy(1'b0, mode_sel_pkg::EMCY_COMM);
    test_done();
  end
endmodule : test_profile_mode_selector
